// ===== verilog/status_pin_pkg.sv
// Shared constants and carrier types for the status pin source selector.
// Assumes a single 125 MHz clock domain and a 32-bit AXI4-Lite register bus.
package status_pin_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_STATUS_SRC = 8'h1b;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
  localparam logic [7:0] IDX_TEST_CTRL = 8'h42;
  localparam int ADDR_W = 12;

  // Field layout of the configuration register.
  localparam int SEL_LSB = 4;
  localparam int SEL_W = 4;
  localparam int POL_BIT = 3;
  localparam logic [3:0] SEL_RESET = 4'h5;
  localparam logic POL_RESET = 1'b1;

  // Test control register fields.
  localparam int TEST_EN_BIT = 0;
  localparam int TEST_LVL_BIT = 1;

  // Interrupt event bits, one per watched indicator rising edge.
  localparam int IRQ_W = 4;
  localparam int IRQ_LOS_PRI = 0;
  localparam int IRQ_LOS_SEC = 1;
  localparam int IRQ_LOL1 = 2;
  localparam int IRQ_LOL2 = 3;

  // Divided clock taps, in the order of the divider bundle.
  localparam int DIV_COUNT = 6;
  localparam int DIV_R1 = 0;
  localparam int DIV_N1 = 1;
  localparam int DIV_R2 = 2;
  localparam int DIV_N2 = 3;
  localparam int DIV_M1 = 4;
  localparam int DIV_M2 = 5;

  // Selector codes.
  localparam logic [3:0] CODE_LOS_PRI = 4'h0;
  localparam logic [3:0] CODE_LOS_SEC = 4'h1;
  localparam logic [3:0] CODE_LOL1 = 4'h2;
  localparam logic [3:0] CODE_R1 = 4'h3;
  localparam logic [3:0] CODE_N1 = 4'h4;
  localparam logic [3:0] CODE_LOL2 = 4'h5;
  localparam logic [3:0] CODE_R2 = 4'h6;
  localparam logic [3:0] CODE_N2 = 4'h7;
  localparam logic [3:0] CODE_CAL1 = 4'h8;
  localparam logic [3:0] CODE_CAL2 = 4'h9;
  localparam logic [3:0] CODE_INT = 4'ha;
  localparam logic [3:0] CODE_M1 = 4'hb;
  localparam logic [3:0] CODE_M2 = 4'hc;
  localparam logic [3:0] CODE_NVM = 4'hd;
  localparam logic [3:0] CODE_SW1 = 4'he;
  localparam logic [3:0] CODE_SW2 = 4'hf;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Level indicators from the rest of the clock generator.
  typedef struct packed {
    logic los_pri;
    logic los_sec;
    logic lol1;
    logic lol2;
    logic cal1;
    logic cal2;
    logic nvm_busy;
    logic sw1;
    logic sw2;
  } indicators_t;

  // Divider output pulses with their bypass flags.
  typedef struct packed {
    logic [DIV_COUNT-1:0] pulse;
    logic [DIV_COUNT-1:0] bypass;
  } dividers_t;

  // Register write request handed from the bus slave to the core.
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } reg_write_t;

endpackage

// ===== verilog/halving_toggle.sv
// Halves the rate of a divider output by toggling on each of its pulses.
// Assumes the pulse input is synchronous to aclk and one cycle wide.
`timescale 1ns/10ps
module halving_toggle
  import status_pin_pkg::*;
(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic pulse, // One pulse per divider period.
  input wire logic bypass, // Divider bypassed, output held low.
  output logic halved // Divider output divided by two.
);

  logic next_halved;

  // A bypassed divider has no meaningful output, so the tap parks low.
  always_comb
  begin
    next_halved = halved;
    if (bypass)
      next_halved = 1'b0;
    else if (pulse)
      next_halved = ~halved;
  end

  // Toggle register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      halved <= 1'b0;
    else
      halved <= next_halved;
  end

endmodule

// ===== verilog/axil_reg_slave.sv
// AXI4-Lite slave front end: one write and one read outstanding at most.
// Assumes the core decodes addresses and returns read data combinationally.
`timescale 1ns/10ps
module axil_reg_slave
  import status_pin_pkg::*;
(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [ADDR_W-1:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [ADDR_W-1:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  output reg_write_t wr, // Write request to the core.
  input wire logic wr_ok, // Write address is mapped.
  output logic [ADDR_W-1:0] rd_addr, // Read address to the core.
  input wire logic [31:0] rd_data, // Read data from the core.
  input wire logic rd_ok // Read address is mapped.
);

  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp, next_rresp;

  // Each channel is refused only while its own slot is full or a reply waits.
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign rd_addr = araddr;

  // The write is committed in the first cycle in which both halves are held.
  always_comb
  begin
    wr.en = aw_held && w_held;
    wr.addr = aw_addr;
    wr.data = w_data;
    wr.strb = w_strb;
  end

  // Capture address and data in either order, then answer once.
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (wr.en)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid && bready)
      next_bvalid = 1'b0;
  end

  // Reads sample the core in the address cycle and answer one cycle later.
  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rdata = rd_ok ? rd_data : 32'h0000_0000;
      next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
      next_rvalid = 1'b0;
  end

  // Channel state registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

endmodule

// ===== verilog/status_pin_source_select.sv
// Status pin source selector: a register picks one internal indicator,
// sets its polarity and drives the first status output; test settings win.
// Assumes indicator and divider inputs are synchronous to aclk.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps

// Functional notes
// - Four-bit selector in bits 7:4, resets to 5.
// - Codes 0, 1 route the two input-loss flags.
// - Code 2 PLL1 unlocked, code 5 PLL2 unlocked.
// - Codes 3, 6 give halved R dividers, unbypassed.
// - Codes 4, 7 give halved N dividers.
// - Codes 8, 9 show VCO calibration in progress.
// - Code 10 shows the flag-derived device interrupt.
// - Codes 11, 12 give halved M dividers, unbypassed.
// - Code 13 memory busy; 14, 15 automatic switchback.
// - Bit 3 polarity, reset 1, one means high.
// - Test settings override selector and polarity.
module status_pin_source_select
  import status_pin_pkg::*;
(
  input wire logic aclk, // System clock, 125 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [ADDR_W-1:0] awaddr, // Write address.
  input wire logic [2:0] awprot, // Write protection, ignored.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [ADDR_W-1:0] araddr, // Read address.
  input wire logic [2:0] arprot, // Read protection, ignored.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  input wire indicators_t indicators, // Level indicators.
  input wire dividers_t dividers, // Divider pulses and bypass flags.
  output logic first_status_output, // Status pin level.
  output logic device_interrupt // Level interrupt to the host.
);

  reg_write_t wr;
  logic wr_ok, rd_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;

  logic [SEL_W-1:0] status_source_selector;
  logic status_output_polarity;
  logic [IRQ_W-1:0] irq_status, irq_mask;
  logic test_en, test_lvl;
  logic [SEL_W-1:0] next_selector;
  logic next_polarity;
  logic [IRQ_W-1:0] next_irq_status, next_irq_mask;
  logic next_test_en, next_test_lvl;

  logic [IRQ_W-1:0] watched, watched_prev, rise;
  logic [DIV_COUNT-1:0] halved;
  logic picked, next_status;

  // The protection bits carry nothing this block distinguishes.
  logic unused_prot;
  assign unused_prot = ^{awprot, arprot};

  axil_reg_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr(wr),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // One halving stage per divider tap.
  genvar gi;
  generate
    for (gi = 0; gi < DIV_COUNT; gi = gi + 1)
    begin : g_half
      halving_toggle u_half (
        .aclk(aclk),
        .aresetn(aresetn),
        .pulse(dividers.pulse[gi]),
        .bypass(dividers.bypass[gi]),
        .halved(halved[gi])
      );
    end
  endgenerate

  // Address decode; the low two byte-address bits must be zero.
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  assign wr_ok = hit(wr.addr, IDX_STATUS_SRC) || hit(wr.addr, IDX_IRQ_STATUS)
              || hit(wr.addr, IDX_IRQ_MASK) || hit(wr.addr, IDX_TEST_CTRL);
  assign rd_ok = hit(rd_addr, IDX_STATUS_SRC) || hit(rd_addr, IDX_IRQ_STATUS)
              || hit(rd_addr, IDX_IRQ_MASK) || hit(rd_addr, IDX_TEST_CTRL);

  // Read mux; everything above the defined fields reads as zero.
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit(rd_addr, IDX_STATUS_SRC))
    begin
      rd_data[SEL_LSB +: SEL_W] = status_source_selector;
      rd_data[POL_BIT] = status_output_polarity;
      rd_data[2:0] = 3'h0;
    end
    else if (hit(rd_addr, IDX_IRQ_STATUS))
      rd_data[IRQ_W-1:0] = irq_status;
    else if (hit(rd_addr, IDX_IRQ_MASK))
      rd_data[IRQ_W-1:0] = irq_mask;
    else if (hit(rd_addr, IDX_TEST_CTRL))
    begin
      rd_data[TEST_EN_BIT] = test_en;
      rd_data[TEST_LVL_BIT] = test_lvl;
    end
  end

  // Rising edges of the loss indicators are the interrupt events.
  assign watched = {indicators.lol2, indicators.lol1,
                    indicators.los_sec, indicators.los_pri};
  assign rise = watched & ~watched_prev;

  // Register writes; only byte lane 0 carries defined bits.
  always_comb
  begin
    next_selector = status_source_selector;
    next_polarity = status_output_polarity;
    next_irq_mask = irq_mask;
    next_test_en = test_en;
    next_test_lvl = test_lvl;
    next_irq_status = irq_status;
    if (wr.en && wr.strb[0])
    begin
      if (hit(wr.addr, IDX_STATUS_SRC))
      begin
        next_selector = wr.data[SEL_LSB +: SEL_W];
        next_polarity = wr.data[POL_BIT];
        // Bits 2:0 have no storage, so writes there vanish.
      end
      if (hit(wr.addr, IDX_IRQ_MASK))
        next_irq_mask = wr.data[IRQ_W-1:0];
      if (hit(wr.addr, IDX_TEST_CTRL))
      begin
        next_test_en = wr.data[TEST_EN_BIT];
        next_test_lvl = wr.data[TEST_LVL_BIT];
      end
      if (hit(wr.addr, IDX_IRQ_STATUS))
        next_irq_status = irq_status & ~wr.data[IRQ_W-1:0];
    end
    // A new event wins over a clear in the same cycle.
    next_irq_status = next_irq_status | rise;
  end

  // Configuration and interrupt registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_source_selector <= SEL_RESET;
      status_output_polarity <= POL_RESET;
      irq_status <= '0;
      irq_mask <= '0;
      test_en <= 1'b0;
      test_lvl <= 1'b0;
      watched_prev <= '0;
    end
    else
    begin
      status_source_selector <= next_selector;
      status_output_polarity <= next_polarity;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      test_en <= next_test_en;
      test_lvl <= next_test_lvl;
      watched_prev <= watched;
    end
  end

  // The interrupt level follows the sticky flags through the mask.
  assign device_interrupt = |(irq_status & irq_mask);

  // Source selection; all sixteen codes are legal, so no default is needed.
  always_comb
  begin
    picked = 1'b0;
    unique case (status_source_selector)
      CODE_LOS_PRI: picked = indicators.los_pri;
      CODE_LOS_SEC: picked = indicators.los_sec;
      CODE_LOL1: picked = indicators.lol1;
      CODE_LOL2: picked = indicators.lol2;
      CODE_R1: picked = halved[DIV_R1];
      CODE_R2: picked = halved[DIV_R2];
      CODE_N1: picked = halved[DIV_N1];
      CODE_N2: picked = halved[DIV_N2];
      CODE_CAL1: picked = indicators.cal1;
      CODE_CAL2: picked = indicators.cal2;
      CODE_INT: picked = device_interrupt;
      CODE_M1: picked = halved[DIV_M1];
      CODE_M2: picked = halved[DIV_M2];
      CODE_NVM: picked = indicators.nvm_busy;
      CODE_SW1: picked = indicators.sw1;
      CODE_SW2: picked = indicators.sw2;
    endcase
  end

  // Polarity, then the test override, which bypasses both settings.
  always_comb
  begin
    next_status = status_output_polarity ? picked : ~picked;
    if (test_en)
      next_status = test_lvl;
  end

  // The pin is registered so that mux switching cannot glitch it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      first_status_output <= 1'b0;
    else
      first_status_output <= next_status;
  end

endmodule

// ===== test/board_partner.sv
// Board-side model: drives indicator levels and divider pulses into the
// selector, and counts the transitions that it sees on the status pin.
// Assumes the bench changes its commands just after rising edges of aclk.
`timescale 1ns/10ps
module board_partner
  import status_pin_pkg::*;
(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire indicators_t level_cmd, // Levels asked for by the bench.
  input wire logic [DIV_COUNT-1:0] fire_cmd, // One pulse per cycle held.
  input wire logic [DIV_COUNT-1:0] bypass_cmd, // Divider bypass settings.
  input wire logic status_pin, // Observed status pin.
  output indicators_t indicators, // Levels into the selector.
  output dividers_t dividers, // Pulses and bypass into the selector.
  output logic [15:0] pin_edges // Status pin transitions since reset.
);
  logic last_pin;

  // Everything is registered so that it changes only just after an edge,
  // as the generator's own flags and divider outputs would.
  always_ff @(posedge aclk)
  begin
    indicators <= level_cmd;
    dividers.pulse <= fire_cmd;
    dividers.bypass <= bypass_cmd;
    last_pin <= status_pin;
    if (!aresetn)
      pin_edges <= 16'h0000;
    else if (status_pin !== last_pin)
      pin_edges <= pin_edges + 16'h0001;
  end
endmodule

// ===== test/status_pin_source_select_props.sv
// Concurrent checks on the selector's ports: bus answers and pin defaults.
// Assumes it is bound into the top module and sees only its ports.
`timescale 1ns/10ps
module status_pin_source_select_props
  import status_pin_pkg::*;
(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic awvalid, // Write address valid.
  input wire logic awready, // Write address ready.
  input wire logic wvalid, // Write data valid.
  input wire logic wready, // Write data ready.
  input wire logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic arvalid, // Read address valid.
  input wire logic arready, // Read address ready.
  input wire logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  input wire indicators_t indicators, // Indicator levels.
  input wire logic first_status_output, // Status pin.
  input wire logic device_interrupt // Level interrupt.
);
  logic wrote;
  logic next_wrote;

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Any accepted write may move the source, so the default check stops.
  always_comb
  begin
    next_wrote = wrote | (awvalid & awready);
    if (!aresetn)
      next_wrote = 1'b0;
  end

  // Register the write-seen flag.
  always_ff @(posedge aclk)
  begin
    wrote <= next_wrote;
  end

  a_pin_reset: assert property ($rose(aresetn) |-> !first_status_output)
    else $error("status pin not low after reset");
  a_irq_reset: assert property ($rose(aresetn) |-> !device_interrupt)
    else $error("interrupt high after reset");
  a_default_src: assert property (aresetn && $past(aresetn) && !wrote
    |-> first_status_output == $past(indicators.lol2))
    else $error("default source is not the second unlocked flag");
  a_write_lat: assert property (awvalid && awready && wvalid && wready
    |=> !bvalid ##1 bvalid)
    else $error("write answer not two cycles after acceptance");
  a_read_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer not one cycle after acceptance");
  a_b_blocks: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while a response is pending");
  a_r_blocks: assert property (rvalid |-> !arready)
    else $error("read accepted while read data is pending");
  a_bvalid_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  a_rvalid_drop: assert property (rvalid && rready |=> !rvalid)
    else $error("read data repeated");

  c_write: cover property (awvalid && awready);
  c_irq: cover property ($rose(device_interrupt));
  c_pin: cover property ($rose(first_status_output));
endmodule

// ===== test/status_pin_source_select_tb.sv
// Self-checking bench for the status pin selector over AXI4-Lite.
// Assumes the board partner model and the bound property checker.
`timescale 1ns/10ps
module status_pin_source_select_tb
  import status_pin_pkg::*;
;
  localparam logic [11:0] A_CFG = {2'b00, IDX_STATUS_SRC, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_MASK = {2'b00, IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_TEST = {2'b00, IDX_TEST_CTRL, 2'b00};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, first_status_output;
  logic device_interrupt;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  indicators_t indicators, level_cmd;
  dividers_t dividers;
  logic [5:0] fire_cmd, bypass_cmd;
  logic [15:0] pin_edges;
  int n_errors = 0;
  int comparisons = 0;

  status_pin_source_select dut (.aclk, .aresetn, .awaddr, .awprot(3'h0),
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .indicators, .dividers, .first_status_output,
    .device_interrupt);
  board_partner partner (.aclk, .aresetn, .level_cmd, .fire_cmd, .bypass_cmd,
    .status_pin(first_status_output), .indicators, .dividers, .pin_edges);

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t pin %h exp %h", $time, got, exp);
    end
  endtask

  // Address and data go out together; each drops once it is taken.
  task automatic bus_write(input logic [11:0] a, input logic [31:0] d,
    output logic [1:0] resp);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_left || w_left)
    begin
      @(posedge aclk);
      if (aw_left && awready)
      begin
        aw_left = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_left && wready)
      begin
        w_left = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do
      @(posedge aclk);
    while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  task automatic bus_read(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    do
      @(posedge aclk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
  endtask

  task automatic settle;
    repeat (4) @(posedge aclk);
  endtask

  task automatic set_cfg(input logic [3:0] code, input logic pol);
    logic [1:0] r;
    bus_write(A_CFG, {24'h0, code, pol, 3'b000}, r);
    settle();
  endtask

  task automatic fire(input logic [5:0] m);
    fire_cmd <= m;
    @(posedge aclk);
    fire_cmd <= 6'h00;
    settle();
  endtask

  task automatic t_reset_defaults;
    logic [31:0] d;
    logic [1:0] r;
    bus_read(A_CFG, d, r);
    check_word(d, 32'h0000_0058);
    level_cmd <= indicators_t'(9'h020);
    settle();
    check_pin(first_status_output, 1'b1);
    level_cmd <= indicators_t'(9'h1df);
    settle();
    check_pin(first_status_output, 1'b0);
    $display("t_reset_defaults done");
  endtask

  task automatic t_reserved_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    bus_write(A_CFG, 32'h0000_00ff, r);
    check_word(32'(r), 32'(RESP_OKAY));
    bus_read(A_CFG, d, r);
    check_word(d, 32'h0000_00f8);
    // Byte lane 0 off: the write is answered but must leave the fields.
    wstrb <= 4'he;
    bus_write(A_CFG, 32'h0000_0000, r);
    wstrb <= 4'hf;
    check_word(32'(r), 32'(RESP_OKAY));
    bus_read(A_CFG, d, r);
    check_word(d, 32'h0000_00f8);
    bus_write(12'h3fc, 32'hffff_ffff, r);
    check_word(32'(r), 32'(RESP_SLVERR));
    bus_read(12'h3fc, d, r);
    check_word(d, 32'h0000_0000);
    check_word(32'(r), 32'(RESP_SLVERR));
    $display("t_reserved_unmapped done");
  endtask

  // Codes listed in the order of the indicator bundle, msb first.
  task automatic t_level_sources;
    logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h8, 4'h9, 4'hd,
      4'he, 4'hf};
    for (int i = 0; i < 9; i++)
      for (int p = 0; p < 2; p++)
      begin
        set_cfg(codes[i], p[0]);
        level_cmd <= indicators_t'(9'h100 >> i);
        settle();
        check_pin(first_status_output, p[0]);
        level_cmd <= indicators_t'(~(9'h100 >> i));
        settle();
        check_pin(first_status_output, ~p[0]);
      end
    $display("t_level_sources done");
  endtask

  // Codes listed in the order of the divider bundle.
  task automatic t_divider_halving;
    logic [3:0] codes [6] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'hb, 4'hc};
    logic [15:0] e0;
    for (int i = 0; i < 6; i++)
    begin
      set_cfg(codes[i], 1'b1);
      e0 = pin_edges;
      fire(6'h3f & ~(6'h01 << i));
      repeat (3) fire(6'h01 << i);
      check_word({16'h0, pin_edges - e0}, 32'd3);
      if (i != 1 && i != 3)
      begin
        // Odd taps enter high from earlier rounds, so the three pulses leave them low; one more pulse parks
        // the tap high, so that the bypass has to pull the pin down.
        if (i[0])
          fire(6'h01 << i);
        check_pin(first_status_output, 1'b1);
        bypass_cmd <= 6'h01 << i;
        fire(6'h01 << i);
        check_pin(first_status_output, 1'b0);
        bypass_cmd <= 6'h00;
      end
    end
    $display("t_divider_halving done");
  endtask

  task automatic t_interrupt;
    logic [31:0] d;
    logic [1:0] r;
    level_cmd <= indicators_t'(9'h000);
    set_cfg(CODE_INT, 1'b1);
    bus_write(A_STAT, 32'h0000_000f, r);
    bus_write(A_MASK, 32'h0000_0001, r);
    settle();
    check_pin(first_status_output, 1'b0);
    level_cmd <= indicators_t'(9'h100);
    settle();
    check_pin(device_interrupt, 1'b1);
    check_pin(first_status_output, 1'b1);
    bus_read(A_STAT, d, r);
    check_word(d, 32'h0000_0001);
    bus_write(A_MASK, 32'h0000_0000, r);
    settle();
    check_pin(first_status_output, 1'b0);
    bus_write(A_MASK, 32'h0000_0001, r);
    settle();
    check_pin(device_interrupt, 1'b1);
    bus_write(A_STAT, 32'h0000_0001, r);
    settle();
    check_pin(device_interrupt, 1'b0);
    check_pin(first_status_output, 1'b0);
    $display("t_interrupt done");
  endtask

  task automatic t_test_override;
    logic [1:0] r;
    level_cmd <= indicators_t'(9'h100);
    set_cfg(CODE_LOS_PRI, 1'b0);
    check_pin(first_status_output, 1'b0);
    bus_write(A_TEST, 32'h0000_0003, r);
    settle();
    check_pin(first_status_output, 1'b1);
    level_cmd <= indicators_t'(9'h000);
    bus_write(A_TEST, 32'h0000_0001, r);
    settle();
    check_pin(first_status_output, 1'b0);
    bus_write(A_TEST, 32'h0000_0000, r);
    settle();
    check_pin(first_status_output, 1'b1);
    $display("t_test_override done");
  endtask

  task automatic final_report;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Free-running 125 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Main sequence; the responses are always accepted at once.
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'b000;
    {bready, rready} = 2'b11;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hf;
    level_cmd = indicators_t'(9'h000);
    fire_cmd = 6'h00;
    bypass_cmd = 6'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_defaults();
    t_reserved_unmapped();
    t_level_sources();
    t_divider_halving();
    t_interrupt();
    t_test_override();
    final_report();
  end

  // The tests need several hundred cycles; this cuts a hang short.
  initial
  begin
    #200000;
    n_errors++;
    final_report();
  end
endmodule

bind status_pin_source_select status_pin_source_select_props props_i (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .arvalid, .arready, .rvalid, .rready, .indicators, .first_status_output,
  .device_interrupt);
